//--- core/ssla_pkg.sv
package ssla_pkg;
  // register byte offsets (aligned words on apb)
  localparam logic [11:0] ADDR_DATA_LINE = 12'h000;
  localparam logic [11:0] ADDR_CLOCK_LINE = 12'h004;
  localparam logic [11:0] ADDR_LINE_CONTROL = 12'h008;
  localparam logic [11:0] ADDR_FALL_COND = 12'h00C;
  localparam logic [11:0] ADDR_RISE_COND = 12'h010;
  localparam logic [11:0] ADDR_SAMPLED_DATA = 12'h014;
  localparam logic [11:0] ADDR_CLOCK_RISE = 12'h018;
  // control field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_UNCOND_BIT = 1;
  localparam int CTRL_COND_BIT = 2;
  localparam int CTRL_STRETCH_BIT = 3;
  // reset values
  localparam logic DRIVE_RESET = 1'b1;
  localparam logic FLAG_RESET = 1'b0;
  typedef struct packed {
    logic clk_in;
    logic dat_in;
  } ssla_lines_t;
endpackage : ssla_pkg

//--- core/ssla_top.sv
`timescale 1ns/1ps
`default_nettype none
module ssla_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_b_line_four_i,
  output logic port_b_line_four_o,
  output logic port_b_line_four_oe,
  input wire logic port_b_line_five_i,
  output logic port_b_line_five_o,
  output logic port_b_line_five_oe,
  input wire logic port_b_four_gpio_o,
  input wire logic port_b_four_gpio_oe,
  input wire logic port_b_five_gpio_o,
  input wire logic port_b_five_gpio_oe,
  output logic falling_condition_irq,
  output logic rising_condition_irq
);
  ssla_pkg::ssla_lines_t meta_r;
  ssla_pkg::ssla_lines_t sync_r;
  ssla_pkg::ssla_lines_t prev_r;
  logic data_line_drive_bit_r;
  logic clock_line_drive_bit_r;
  logic line_assist_enable_r;
  logic unconditional_stretch_enable_r;
  logic conditional_stretch_enable_r;
  logic stretch_active_flag_r;
  logic falling_data_condition_flag_r;
  logic rising_data_condition_flag_r;
  logic sampled_data_bit_r;
  logic clock_rise_flag_r;
  logic clk_rise;
  logic clk_fall;
  logic cond_fall;
  logic cond_rise;
  logic setup_ok;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic [31:0] rd_nxt;
  logic clk_drive_low;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction : hit

  // first stage read only by second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
    end else begin
      meta_r <= '{clk_in: port_b_line_four_i, dat_in: port_b_line_five_i};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign clk_rise = sync_r.clk_in && !prev_r.clk_in;
  assign clk_fall = !sync_r.clk_in && prev_r.clk_in;
  assign cond_fall = prev_r.dat_in && !sync_r.dat_in && sync_r.clk_in && prev_r.clk_in;
  assign cond_rise = !prev_r.dat_in && sync_r.dat_in && sync_r.clk_in && prev_r.clk_in;

  // zero wait state slave
  assign setup_ok = psel && penable;
  assign wr_acc = setup_ok && pwrite;
  assign rd_acc = setup_ok && !pwrite;
  assign mapped = hit(paddr, ssla_pkg::ADDR_DATA_LINE) || hit(paddr, ssla_pkg::ADDR_CLOCK_LINE)
    || hit(paddr, ssla_pkg::ADDR_LINE_CONTROL) || hit(paddr, ssla_pkg::ADDR_FALL_COND)
    || hit(paddr, ssla_pkg::ADDR_RISE_COND) || hit(paddr, ssla_pkg::ADDR_SAMPLED_DATA)
    || hit(paddr, ssla_pkg::ADDR_CLOCK_RISE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_line_drive_bit_r <= ssla_pkg::DRIVE_RESET;
      clock_line_drive_bit_r <= ssla_pkg::DRIVE_RESET;
    end else if (wr_acc) begin
      if (hit(paddr, ssla_pkg::ADDR_DATA_LINE)) begin
        data_line_drive_bit_r <= pwdata[0];
      end
      if (hit(paddr, ssla_pkg::ADDR_CLOCK_LINE)) begin
        clock_line_drive_bit_r <= pwdata[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_assist_enable_r <= 1'b0;
      unconditional_stretch_enable_r <= 1'b0;
      conditional_stretch_enable_r <= 1'b0;
    end else if (wr_acc && hit(paddr, ssla_pkg::ADDR_LINE_CONTROL)) begin
      line_assist_enable_r <= pwdata[ssla_pkg::CTRL_ENABLE_BIT];
      unconditional_stretch_enable_r <= pwdata[ssla_pkg::CTRL_UNCOND_BIT];
      conditional_stretch_enable_r <= pwdata[ssla_pkg::CTRL_COND_BIT];
    end
  end

  // set wins over a same-cycle clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      falling_data_condition_flag_r <= ssla_pkg::FLAG_RESET;
      rising_data_condition_flag_r <= ssla_pkg::FLAG_RESET;
    end else begin
      if (line_assist_enable_r && cond_fall) begin
        falling_data_condition_flag_r <= 1'b1;
      end else if (wr_acc && hit(paddr, ssla_pkg::ADDR_FALL_COND)) begin
        falling_data_condition_flag_r <= 1'b0;
      end
      if (line_assist_enable_r && cond_rise) begin
        rising_data_condition_flag_r <= 1'b1;
      end else if (wr_acc && hit(paddr, ssla_pkg::ADDR_RISE_COND)) begin
        rising_data_condition_flag_r <= 1'b0;
      end
    end
  end

  // one pulse per occurrence, gated by enable like the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      falling_condition_irq <= 1'b0;
      rising_condition_irq <= 1'b0;
    end else begin
      falling_condition_irq <= line_assist_enable_r && cond_fall;
      rising_condition_irq <= line_assist_enable_r && cond_rise;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampled_data_bit_r <= 1'b0;
      clock_rise_flag_r <= 1'b0;
    end else begin
      if (clk_rise) begin
        sampled_data_bit_r <= sync_r.dat_in;
      end
      if (clk_rise) begin
        clock_rise_flag_r <= 1'b1;
      end else if (rd_acc && hit(paddr, ssla_pkg::ADDR_SAMPLED_DATA)) begin
        clock_rise_flag_r <= 1'b0;
      end
    end
  end

  // a new fall during the release write wins, so no stretch is missed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_active_flag_r <= 1'b0;
    end else if (line_assist_enable_r && clk_fall && (unconditional_stretch_enable_r
        || (conditional_stretch_enable_r && falling_data_condition_flag_r))) begin
      stretch_active_flag_r <= 1'b1;
    end else if (wr_acc && hit(paddr, ssla_pkg::ADDR_SAMPLED_DATA)) begin
      stretch_active_flag_r <= 1'b0;
    end
  end

  assign clk_drive_low = !clock_line_drive_bit_r || stretch_active_flag_r;

  // open drain: only ever drive low; pass-through of the port when disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_line_four_o <= 1'b0;
      port_b_line_four_oe <= 1'b0;
      port_b_line_five_o <= 1'b0;
      port_b_line_five_oe <= 1'b0;
    end else if (line_assist_enable_r) begin
      port_b_line_four_o <= 1'b0;
      port_b_line_four_oe <= clk_drive_low;
      port_b_line_five_o <= 1'b0;
      port_b_line_five_oe <= !data_line_drive_bit_r;
    end else begin
      port_b_line_four_o <= port_b_four_gpio_o;
      port_b_line_four_oe <= port_b_four_gpio_oe;
      port_b_line_five_o <= port_b_five_gpio_o;
      port_b_line_five_oe <= port_b_five_gpio_oe;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (1'b1)
      hit(paddr, ssla_pkg::ADDR_DATA_LINE): rd_nxt[0] = sync_r.dat_in;
      hit(paddr, ssla_pkg::ADDR_CLOCK_LINE): rd_nxt[0] = sync_r.clk_in;
      hit(paddr, ssla_pkg::ADDR_LINE_CONTROL): begin
        rd_nxt[ssla_pkg::CTRL_ENABLE_BIT] = line_assist_enable_r;
        rd_nxt[ssla_pkg::CTRL_UNCOND_BIT] = unconditional_stretch_enable_r;
        rd_nxt[ssla_pkg::CTRL_COND_BIT] = conditional_stretch_enable_r;
        rd_nxt[ssla_pkg::CTRL_STRETCH_BIT] = stretch_active_flag_r;
      end
      hit(paddr, ssla_pkg::ADDR_FALL_COND): rd_nxt[0] = falling_data_condition_flag_r;
      hit(paddr, ssla_pkg::ADDR_RISE_COND): rd_nxt[0] = rising_data_condition_flag_r;
      hit(paddr, ssla_pkg::ADDR_SAMPLED_DATA): rd_nxt[0] = sampled_data_bit_r;
      hit(paddr, ssla_pkg::ADDR_CLOCK_RISE): rd_nxt[0] = clock_rise_flag_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // registered answer: setup cycle computes, access cycle presents
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0000_0000;
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  a_fall_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    (line_assist_enable_r && cond_fall) |=> falling_data_condition_flag_r && falling_condition_irq)
    else $error("condition one not flagged");
  a_rise_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    (line_assist_enable_r && cond_rise) |=> rising_data_condition_flag_r && rising_condition_irq)
    else $error("condition two not flagged");
  a_fall_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, ssla_pkg::ADDR_FALL_COND) && !(line_assist_enable_r && cond_fall))
    |=> !falling_data_condition_flag_r) else $error("condition one not cleared");
  a_rise_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, ssla_pkg::ADDR_RISE_COND) && !(line_assist_enable_r && cond_rise))
    |=> !rising_data_condition_flag_r) else $error("condition two not cleared");
  a_no_flag_off: assert property (@(posedge pclk) disable iff (!presetn)
    !line_assist_enable_r && !falling_data_condition_flag_r |=> !falling_data_condition_flag_r)
    else $error("flag set while disabled");
  a_sample_taken: assert property (@(posedge pclk) disable iff (!presetn)
    clk_rise |=> sampled_data_bit_r == $past(sync_r.dat_in) && clock_rise_flag_r)
    else $error("sample not taken on clock rise");
  a_stretch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (line_assist_enable_r && clk_fall && unconditional_stretch_enable_r)
    |=> stretch_active_flag_r ##1 port_b_line_four_oe) else $error("clock not held low");
  a_stretch_release: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, ssla_pkg::ADDR_SAMPLED_DATA) && !clk_fall)
    |=> !stretch_active_flag_r) else $error("stretch not released");
  a_data_open_drain: assert property (@(posedge pclk) disable iff (!presetn)
    line_assist_enable_r |=> !port_b_line_five_o && (port_b_line_five_oe == !$past(data_line_drive_bit_r)))
    else $error("data line not open drain");

  a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("no answer after setup cycle");

  a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready stood longer than one cycle");

  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !mapped) |=> pslverr)
    else $error("unmapped access not refused");

  a_data_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, ssla_pkg::ADDR_DATA_LINE)) |=> data_line_drive_bit_r == $past(pwdata[0]))
    else $error("data drive bit not written");

  a_clock_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, ssla_pkg::ADDR_CLOCK_LINE)) |=> clock_line_drive_bit_r == $past(pwdata[0]))
    else $error("clock drive bit not written");

  a_clock_pulls_low: assert property (@(posedge pclk) disable iff (!presetn)
    (line_assist_enable_r && !clock_line_drive_bit_r) |=> port_b_line_four_oe)
    else $error("clock line not pulled low");

  a_clock_open_drain: assert property (@(posedge pclk) disable iff (!presetn)
    line_assist_enable_r |=> !port_b_line_four_o)
    else $error("clock line driven high");

  a_disabled_pass: assert property (@(posedge pclk) disable iff (!presetn)
    !line_assist_enable_r |=> port_b_line_four_oe == $past(port_b_four_gpio_oe))
    else $error("port setting not passed through");

  a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, ssla_pkg::ADDR_LINE_CONTROL))
    |=> line_assist_enable_r == $past(pwdata[ssla_pkg::CTRL_ENABLE_BIT]))
    else $error("enable bit not written");

  a_ctrl_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && !mapped) |=> $stable(line_assist_enable_r))
    else $error("refused write changed control");

  a_fall_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (falling_data_condition_flag_r && !(wr_acc && hit(paddr, ssla_pkg::ADDR_FALL_COND)))
    |=> falling_data_condition_flag_r)
    else $error("condition one flag lost");

  a_rise_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (rising_data_condition_flag_r && !(wr_acc && hit(paddr, ssla_pkg::ADDR_RISE_COND)))
    |=> rising_data_condition_flag_r)
    else $error("condition two flag lost");

  a_no_rise_off: assert property (@(posedge pclk) disable iff (!presetn)
    !line_assist_enable_r && !rising_data_condition_flag_r |=> !rising_data_condition_flag_r)
    else $error("condition two set while disabled");

  a_fall_irq_off: assert property (@(posedge pclk) disable iff (!presetn)
    !(line_assist_enable_r && cond_fall) |=> !falling_condition_irq)
    else $error("spurious condition one request");

  a_rise_irq_off: assert property (@(posedge pclk) disable iff (!presetn)
    !(line_assist_enable_r && cond_rise) |=> !rising_condition_irq)
    else $error("spurious condition two request");

  a_sample_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_rise |=> $stable(sampled_data_bit_r))
    else $error("sample changed without clock rise");

  a_edge_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && hit(paddr, ssla_pkg::ADDR_SAMPLED_DATA) && !clk_rise) |=> !clock_rise_flag_r)
    else $error("clock rise flag not cleared by read");

  a_cond_stretch: assert property (@(posedge pclk) disable iff (!presetn)
    (line_assist_enable_r && clk_fall && conditional_stretch_enable_r
    && falling_data_condition_flag_r) |=> stretch_active_flag_r)
    else $error("conditional stretch not started");

  a_no_stretch: assert property (@(posedge pclk) disable iff (!presetn)
    (!stretch_active_flag_r && !(line_assist_enable_r && clk_fall)) |=> !stretch_active_flag_r)
    else $error("stretch started without clock fall");

  a_stretch_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (line_assist_enable_r && stretch_active_flag_r) |=> port_b_line_four_oe)
    else $error("stretch flag set but clock released");

  a_stretch_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (stretch_active_flag_r && !(wr_acc && hit(paddr, ssla_pkg::ADDR_SAMPLED_DATA)))
    |=> stretch_active_flag_r)
    else $error("stretch ended without release write");
endmodule : ssla_top
`default_nettype wire

//--- test/ssla_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ssla_peer (
  input wire logic clk_low,
  input wire logic dat_low,
  input wire logic clk_o,
  input wire logic clk_oe,
  input wire logic dat_o,
  input wire logic dat_oe,
  output logic clk_pad,
  output logic dat_pad
);
  // wired-and with pull-up, so a released line reads 1
  assign clk_pad = !(clk_low || (clk_oe && !clk_o));
  assign dat_pad = !(dat_low || (dat_oe && !dat_o));
endmodule : ssla_peer
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic f4o, f4oe, f5o, f5oe, c4, c5, g4o, g4oe, irq_f, irq_r, clk_low, dat_low;
  int n_fail, samples_checked, n_f, n_r;
  logic [31:0] rv [7] = '{32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  ssla_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_b_line_four_i(c4), .port_b_line_four_o(f4o),
    .port_b_line_four_oe(f4oe), .port_b_line_five_i(c5), .port_b_line_five_o(f5o),
    .port_b_line_five_oe(f5oe), .port_b_four_gpio_o(g4o), .port_b_four_gpio_oe(g4oe),
    .port_b_five_gpio_o(1'b1), .port_b_five_gpio_oe(1'b0),
    .falling_condition_irq(irq_f), .rising_condition_irq(irq_r));
  ssla_peer peer_u (.clk_low(clk_low), .dat_low(dat_low), .clk_o(f4o), .clk_oe(f4oe),
    .dat_o(f5o), .dat_oe(f5oe), .clk_pad(c4), .dat_pad(c5));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // irq outputs are one-cycle pulses, so count them every edge
  always @(posedge pclk) begin
    if (irq_f === 1'b1) n_f++;
    if (irq_r === 1'b1) n_r++;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd
  // data is changed only while the link clock is low, so no condition fires
  task automatic sample(input logic b);
    clk_low <= 1'b1;
    cyc(4);
    dat_low <= !b;
    cyc(4);
    clk_low <= 1'b0;
    cyc(6);
  endtask : sample
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_sim();
  end
  initial begin
    {presetn, psel, penable, pwrite, g4o, g4oe, clk_low, dat_low} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_fail = 0;
    samples_checked = 0;
    n_f = 0;
    n_r = 0;
    cyc(16);
    presetn <= 1'b1;
    cyc(1);
    for (int i = 0; i < 7; i++) rd(12'(4 * i), rv[i]);
    rd(12'h01C, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, ssla_pkg::ADDR_LINE_CONTROL, 32'h1);
    g4oe <= 1'b1;
    cyc(3);
    chk({31'h0, f4oe}, 32'h0);
    apb(1'b1, ssla_pkg::ADDR_DATA_LINE, 32'h0);
    cyc(4);
    chk({30'h0, f5o, f5oe}, 32'h1);
    rd(ssla_pkg::ADDR_DATA_LINE, 32'h0);
    apb(1'b1, ssla_pkg::ADDR_DATA_LINE, 32'h1);
    apb(1'b1, ssla_pkg::ADDR_CLOCK_LINE, 32'h0);
    cyc(4);
    chk({30'h0, f4o, f4oe}, 32'h1);
    rd(ssla_pkg::ADDR_CLOCK_LINE, 32'h0);
    apb(1'b1, ssla_pkg::ADDR_CLOCK_LINE, 32'h1);
    cyc(4);
    rd(ssla_pkg::ADDR_CLOCK_LINE, 32'h1);
    clk_low <= 1'b1;
    cyc(4);
    rd(ssla_pkg::ADDR_CLOCK_LINE, 32'h0);
    clk_low <= 1'b0;
    apb(1'b1, ssla_pkg::ADDR_FALL_COND, 32'h0);
    apb(1'b1, ssla_pkg::ADDR_RISE_COND, 32'h0);
    n_f = 0;
    n_r = 0;
    dat_low <= 1'b1;
    cyc(6);
    chk(32'(n_f), 32'h1);
    rd(ssla_pkg::ADDR_FALL_COND, 32'h1);
    apb(1'b1, ssla_pkg::ADDR_FALL_COND, 32'h5);
    rd(ssla_pkg::ADDR_FALL_COND, 32'h0);
    dat_low <= 1'b0;
    cyc(6);
    chk(32'(n_r), 32'h1);
    rd(ssla_pkg::ADDR_RISE_COND, 32'h1);
    apb(1'b1, ssla_pkg::ADDR_RISE_COND, 32'h0);
    rd(ssla_pkg::ADDR_RISE_COND, 32'h0);
    apb(1'b1, ssla_pkg::ADDR_LINE_CONTROL, 32'h0);
    cyc(2);
    chk({31'h0, f4oe}, 32'h1);
    g4oe <= 1'b0;
    cyc(6);
    n_f = 0;
    n_r = 0;
    dat_low <= 1'b1;
    cyc(6);
    dat_low <= 1'b0;
    cyc(6);
    chk(32'(n_f + n_r), 32'h0);
    rd(ssla_pkg::ADDR_FALL_COND, 32'h0);
    rd(ssla_pkg::ADDR_RISE_COND, 32'h0);
    apb(1'b1, ssla_pkg::ADDR_LINE_CONTROL, 32'h1);
    sample(1'b1);
    rd(ssla_pkg::ADDR_CLOCK_RISE, 32'h1);
    rd(ssla_pkg::ADDR_SAMPLED_DATA, 32'h1);
    rd(ssla_pkg::ADDR_CLOCK_RISE, 32'h0);
    sample(1'b0);
    apb(1'b1, ssla_pkg::ADDR_SAMPLED_DATA, 32'h1);
    rd(ssla_pkg::ADDR_SAMPLED_DATA, 32'h0);
    apb(1'b1, ssla_pkg::ADDR_LINE_CONTROL, 32'h3);
    clk_low <= 1'b1;
    cyc(6);
    clk_low <= 1'b0;
    cyc(4);
    chk({30'h0, f4o, f4oe}, 32'h1);
    rd(ssla_pkg::ADDR_LINE_CONTROL, 32'hB);
    apb(1'b1, ssla_pkg::ADDR_SAMPLED_DATA, 32'h0);
    cyc(3);
    chk({31'h0, f4oe}, 32'h0);
    rd(ssla_pkg::ADDR_LINE_CONTROL, 32'h3);
    apb(1'b1, ssla_pkg::ADDR_LINE_CONTROL, 32'h5);
    clk_low <= 1'b1;
    cyc(6);
    chk({31'h0, f4oe}, 32'h0);
    clk_low <= 1'b0;
    cyc(6);
    dat_low <= 1'b0;
    cyc(6);
    dat_low <= 1'b1;
    cyc(6);
    clk_low <= 1'b1;
    cyc(6);
    clk_low <= 1'b0;
    cyc(4);
    chk({31'h0, f4oe}, 32'h1);
    rd(ssla_pkg::ADDR_LINE_CONTROL, 32'hD);
    apb(1'b1, ssla_pkg::ADDR_SAMPLED_DATA, 32'h0);
    cyc(3);
    chk({31'h0, f4oe}, 32'h0);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(2);
    rd(ssla_pkg::ADDR_LINE_CONTROL, 32'h0);
    rd(ssla_pkg::ADDR_FALL_COND, 32'h0);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
